/* File: hdl/plmc_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module plmc_fifo #(
  parameter W     = 12,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,       // Master clock
  input  wire         sys_rst,   // Synchronous reset, high
  input  wire         in_valid,  // Write request
  output wire         in_ready,  // Space available
  input  wire [W-1:0] in_data,   // Write data
  output wire         out_valid, // Data available
  input  wire         out_ready, // Read accept
  output wire [W-1:0] out_data   // Head of queue
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire do_wr;
  wire do_rd;

  localparam integer  DEPTH_I  = DEPTH;
  localparam integer  LAST_I   = DEPTH - 1;
  localparam [AW:0]   FULL_CNT = DEPTH_I[AW:0];
  localparam [AW-1:0] LAST_IDX = LAST_I[AW-1:0];

  assign in_ready  = (count != FULL_CNT);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == LAST_IDX) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == LAST_IDX) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/plmc_map.vh */
// Constants for the power-line FSK modem control block
`ifndef PLMC_MAP_VH
`define PLMC_MAP_VH

// Master clock rate of this implementation, Hz
`define PLMC_CLK_HZ        125000000
// Crystal rate of the original tone generator, Hz
`define PLMC_XTAL_HZ       11059200

// Line frequencies, Hz
`define PLMC_CARRIER_HZ    132450
`define PLMC_TONE0_HZ      133050
`define PLMC_TONE1_HZ      131850
`define PLMC_IF_HZ         5400
`define PLMC_BAND_HALF_HZ  6000

// Highest bit rate, bits per second
`define PLMC_BIT_RATE      1200

// Watchdog timeout, ms, and restart pulse length, cycles
`define PLMC_WDOG_MS       1500
`define PLMC_RST_HOLD_CYC  1024

// Widths and depths
`define PLMC_PHASE_W       32
`define PLMC_PER_W         12
`define PLMC_FIFO_DEPTH    16
`define PLMC_FIFO_AW       4

// Carrier detect: in-band periods counted before the next one sets detect, periods of silence allowed
`define PLMC_CD_LOCK       8
`define PLMC_CD_LOSS_PER   4

`endif

/* File: hdl/plmc_modem.v */
// Power-line FSK modem control: tones, local oscillator, carrier detect, watchdog
//
// Functional notes
// - Half duplex only, bits up to 1200 bps
// - Nominal carrier 132.45 kHz both directions
// - Host bits asynchronous; modulator follows level directly
// - Bit zero 133.05 kHz, bit one 131.85 kHz
// - Both tones digitally derived from master clock
// - Same synthesizer supplies receive mixer oscillator
// - Carrier-detect output shows line carrier presence
// - No falling edge for 1.5 s: restart host
// - Amplifier enable high transmitting, low receiving
`timescale 1ns/1ps
`default_nettype none

`include "plmc_map.vh"

module plmc_modem #(
  parameter [27:0] WDOG_CYC = `PLMC_WDOG_MS * (`PLMC_CLK_HZ / 1000), // Watchdog timeout in cycles
  parameter [15:0] HOLD_CYC = `PLMC_RST_HOLD_CYC                     // Restart pulse length
) (
  input  wire       clk,                // Master clock
  input  wire       sys_rst,            // Synchronous reset, high
  input  wire       tx_request_in,      // High selects transmit mode
  input  wire       tx_data_in,         // Transmit bit level from host
  input  wire       rx_line_in,         // Limited receive signal from line
  input  wire       wdog_in,            // Watchdog input from host
  output reg        tone_out,           // Modulated tone, square
  output reg  [7:0] tx_phase_out,       // Tone phase, upper bits
  output reg        lo_out,             // Mixer local oscillator, square
  output reg        amp_enable_out,     // Power amplifier control
  output reg        carrier_detect_out, // Carrier present on line
  output reg        rx_data_out,        // Demodulated bit
  output reg        rx_data_valid_out,  // One-cycle pulse per in-band period word
  output reg        host_restart_out    // Restart to host, high
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived constants

  localparam PW = `PLMC_PHASE_W;
  localparam NW = `PLMC_PER_W;

  localparam [63:0] ONE_TURN = 64'h0000000100000000;
  localparam [63:0] CLK64    = `PLMC_CLK_HZ;
  localparam [63:0] INC0_F   = (ONE_TURN * `PLMC_TONE0_HZ) / CLK64;
  localparam [63:0] INC1_F   = (ONE_TURN * `PLMC_TONE1_HZ) / CLK64;
  localparam [63:0] INCL_F   = (ONE_TURN * (`PLMC_CARRIER_HZ - `PLMC_IF_HZ)) / CLK64;

  localparam [PW-1:0] INC_TONE0 = INC0_F[PW-1:0];
  localparam [PW-1:0] INC_TONE1 = INC1_F[PW-1:0];
  localparam [PW-1:0] INC_LO    = INCL_F[PW-1:0];

  // Period limits of the receive band and the decision midpoint
  localparam [31:0] PER_LO_F  = `PLMC_CLK_HZ / (`PLMC_CARRIER_HZ + `PLMC_BAND_HALF_HZ);
  localparam [31:0] PER_HI_F  = `PLMC_CLK_HZ / (`PLMC_CARRIER_HZ - `PLMC_BAND_HALF_HZ);
  localparam [31:0] PER_MID_F = `PLMC_CLK_HZ / `PLMC_CARRIER_HZ;
  localparam [NW-1:0] PER_LO  = PER_LO_F[NW-1:0];
  localparam [NW-1:0] PER_HI  = PER_HI_F[NW-1:0];
  localparam [NW-1:0] PER_MID = PER_MID_F[NW-1:0];
  localparam [NW-1:0] PER_MAX = {NW{1'b1}};

  localparam [31:0] LOSS_F    = `PLMC_CD_LOSS_PER * PER_HI_F;
  localparam [13:0] LOSS_CYC  = LOSS_F[13:0];
  localparam [3:0]  LOCK_CNT  = `PLMC_CD_LOCK;

  // Transmit/receive mode, one-hot
  localparam [1:0] MODE_RX = 2'b01;
  localparam [1:0] MODE_TX = 2'b10;

  // Watchdog states, one-hot
  localparam [1:0] WD_RUN  = 2'b01;
  localparam [1:0] WD_HOLD = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit/receive mode

  reg  [1:0] mode;
  reg  [1:0] next_mode;

  always @* begin
    case (mode)
      MODE_RX: next_mode = tx_request_in ? MODE_TX : MODE_RX;
      MODE_TX: next_mode = tx_request_in ? MODE_TX : MODE_RX;
      default: next_mode = MODE_RX;
    endcase
  end

  // Amplifier enable tracks the registered mode
  always @(posedge clk) begin
    if (sys_rst) begin
      mode           <= MODE_RX;
      amp_enable_out <= 1'b0;
    end else begin
      mode           <= next_mode;
      amp_enable_out <= (next_mode == MODE_TX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tone and local oscillator synthesizer

  reg  [PW-1:0] tx_acc;
  reg  [PW-1:0] lo_acc;
  wire [PW-1:0] tx_inc;

  // Continuous phase across bit changes
  assign tx_inc = tx_data_in ? INC_TONE1 : INC_TONE0;

  always @(posedge clk) begin
    if (sys_rst) begin
      tx_acc       <= {PW{1'b0}};
      lo_acc       <= {PW{1'b0}};
      tone_out     <= 1'b0;
      tx_phase_out <= 8'h00;
      lo_out       <= 1'b0;
    end else begin
      if (mode == MODE_TX) begin
        tx_acc       <= tx_acc + tx_inc;
        tone_out     <= tx_acc[PW-1];
        tx_phase_out <= tx_acc[PW-1:PW-8];
        lo_out       <= 1'b0;
      end else begin
        tone_out     <= 1'b0;
        tx_phase_out <= 8'h00;
        lo_acc       <= lo_acc + INC_LO;
        lo_out       <= lo_acc[PW-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive period measurement into the FIFO

  reg           line_prev;
  reg  [NW-1:0] per_cnt;
  reg           push_valid;
  reg  [NW-1:0] push_data;
  wire          push_ready;
  wire          line_rise;

  assign line_rise = rx_line_in & ~line_prev;

  always @(posedge clk) begin
    if (sys_rst) begin
      line_prev  <= 1'b0;
      per_cnt    <= {NW{1'b0}};
      push_valid <= 1'b0;
      push_data  <= {NW{1'b0}};
    end else begin
      line_prev <= rx_line_in;
      if (push_valid) begin
        // Period count cleared each cycle until the queue takes the word
        if (push_ready) begin
          push_valid <= 1'b0;
          per_cnt    <= per_cnt + 1'b1;
        end else begin
          per_cnt <= {NW{1'b0}};
        end
      end else if (line_rise) begin
        // Rise edge counts as first cycle of the new period
        push_valid <= 1'b1;
        push_data  <= per_cnt;
        per_cnt    <= {{(NW-1){1'b0}}, 1'b1};
      end else if (per_cnt != PER_MAX) begin
        per_cnt <= per_cnt + 1'b1;
      end
    end
  end

  wire          pop_valid;
  wire          pop_ready;
  wire [NW-1:0] pop_data;

  // Evaluation halts while transmitting, so the queue fills
  assign pop_ready = (mode == MODE_RX);

  plmc_fifo #(
    .W     (NW),
    .DEPTH (`PLMC_FIFO_DEPTH),
    .AW    (`PLMC_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Carrier detect and FSK decision

  reg  [3:0]  lock_cnt;
  reg  [13:0] quiet_cnt;
  wire        pop_take;
  wire        in_band;

  // Lock counts in-band words; one stray word clears it
  assign pop_take = pop_valid & pop_ready;
  assign in_band  = (pop_data >= PER_LO) && (pop_data <= PER_HI);

  always @(posedge clk) begin
    if (sys_rst) begin
      lock_cnt           <= 4'h0;
      quiet_cnt          <= 14'h0000;
      carrier_detect_out <= 1'b0;
      rx_data_out        <= 1'b0;
      rx_data_valid_out  <= 1'b0;
    end else begin
      rx_data_valid_out <= 1'b0;
      if (pop_take) begin
        quiet_cnt <= 14'h0000;
        if (in_band) begin
          // Longer period means the lower tone, a one
          rx_data_out       <= (pop_data > PER_MID);
          rx_data_valid_out <= 1'b1;
          if (lock_cnt != LOCK_CNT) begin
            lock_cnt <= lock_cnt + 1'b1;
          end else begin
            carrier_detect_out <= 1'b1;
          end
        end else begin
          lock_cnt           <= 4'h0;
          carrier_detect_out <= 1'b0;
        end
      end else if (mode == MODE_RX) begin
        if (quiet_cnt != LOSS_CYC) begin
          quiet_cnt <= quiet_cnt + 1'b1;
        end else begin
          lock_cnt           <= 4'h0;
          carrier_detect_out <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  reg  [1:0]  wd_state;
  reg  [1:0]  next_wd_state;
  reg  [27:0] wd_cnt;
  reg  [15:0] hold_cnt;
  reg         wdog_prev;
  wire        wdog_fall;
  wire        wd_expired;
  wire        hold_done;

  assign wdog_fall  = wdog_prev & ~wdog_in;
  assign wd_expired = (wd_cnt == WDOG_CYC - 28'h0000001);
  assign hold_done  = (hold_cnt == HOLD_CYC - 16'h0001);

  // Kick in the expiry cycle wins over the timeout
  always @* begin
    case (wd_state)
      WD_RUN:  next_wd_state = (wd_expired && !wdog_fall) ? WD_HOLD : WD_RUN;
      WD_HOLD: next_wd_state = hold_done ? WD_RUN : WD_HOLD;
      default: next_wd_state = WD_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      // Counter held at zero during restart pulse
      wd_state         <= WD_RUN;
      wd_cnt           <= 28'h0000000;
      hold_cnt         <= 16'h0000;
      wdog_prev        <= 1'b0;
      host_restart_out <= 1'b0;
    end else begin
      wd_state         <= next_wd_state;
      wdog_prev        <= wdog_in;
      host_restart_out <= (next_wd_state == WD_HOLD);
      if (wd_state == WD_RUN) begin
        hold_cnt <= 16'h0000;
        if (wdog_fall || wd_expired) begin
          wd_cnt <= 28'h0000000;
        end else begin
          wd_cnt <= wd_cnt + 28'h0000001;
        end
      end else begin
        wd_cnt   <= 28'h0000000;
        hold_cnt <= hold_cnt + 16'h0001;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verification/plmc_host.sv */
// Host controller model: kicks, carrier check, two-bit message
`timescale 1ns/1ps
`default_nettype none
module plmc_host #(parameter BIT_CYC = 4000, parameter KICK_HALF = 750) (
  input  wire logic clk,            // Clock
  input  wire logic kick_en,        // Software alive
  input  wire logic send,           // Start message
  input  wire logic carrier_detect, // Line busy
  output var  logic tx_request,     // Transmit mode
  output var  logic tx_data,        // Bit level
  output var  logic wdog            // Kick line
);
  int kc = 0;
  int bc = 0;
  initial begin
    tx_request = 1'b0;
    tx_data    = 1'b0;
    wdog       = 1'b1;
  end
  always @(posedge clk) begin
    // Stalled software holds the kick line
    kc <= (!kick_en) ? kc : (kc == KICK_HALF - 1) ? 0 : kc + 1;
    if (kick_en && kc == KICK_HALF - 1)
      wdog <= ~wdog;
    if (send && !tx_request) begin
      tx_request <= ~carrier_detect;
      tx_data    <= 1'b0;
      bc         <= 0;
    end else if (tx_request) begin
      bc <= bc + 1;
      if (bc == BIT_CYC - 1)
        tx_data <= 1'b1;
      if (bc == 2 * BIT_CYC - 1)
        tx_request <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verification/plmc_modem_properties.sv */
// Port checker for the modem control block
`timescale 1ns/1ps
`default_nettype none
module plmc_chk #(
  parameter [27:0] WDOG_CYC = 28'hB2D05E0,
  parameter [15:0] HOLD_CYC = 16'h0400
) (
  input wire logic       clk,                // Clock
  input wire logic       sys_rst,            // Reset
  input wire logic       tx_request_in,      // Mode
  input wire logic       wdog_in,            // Kick
  input wire logic       tone_out,           // Tone
  input wire logic [7:0] tx_phase_out,       // Phase
  input wire logic       lo_out,             // Mixer LO
  input wire logic       amp_enable_out,     // Amp
  input wire logic       carrier_detect_out, // Carrier
  input wire logic       rx_data_valid_out,  // Rx strobe
  input wire logic       host_restart_out    // Restart
);
  logic [15:0] hi;
  logic [27:0] qt;
  logic        wq;
  // Length of restart pulse, cycles since last kick
  always @(posedge clk) begin
    wq <= sys_rst ? 1'b0 : wdog_in;
    hi <= (sys_rst || !host_restart_out) ? 16'h0000 : hi + 16'h0001;
    qt <= (sys_rst || host_restart_out || (wq && !wdog_in)) ? 28'h0000000 : qt + 28'h0000001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_amp_follows: assert property (1'b1 |=> amp_enable_out == $past(tx_request_in))
    else $error("amp enable wrong");
  a_tone_idle: assert property (!tx_request_in [*4] |-> !tone_out && tx_phase_out == 8'h00)
    else $error("tone in receive");
  a_lo_idle: assert property (tx_request_in [*4] |-> !lo_out)
    else $error("lo in transmit");
  a_restart_len: assert property ($fell(host_restart_out) |-> hi == HOLD_CYC)
    else $error("restart length");
  a_restart_cap: assert property (hi <= HOLD_CYC)
    else $error("restart too long");
  a_wdog_early: assert property ($rose(host_restart_out) |-> qt + 28'h0000003 >= WDOG_CYC)
    else $error("restart early");
  a_wdog_late: assert property (qt <= WDOG_CYC + 28'h0000003)
    else $error("restart late");
  a_cd_on_word: assert property ($rose(carrier_detect_out) |-> rx_data_valid_out || $past(rx_data_valid_out))
    else $error("carrier without word");
  c_restart: cover property ($rose(host_restart_out));
  c_carrier: cover property ($rose(carrier_detect_out));
  c_send: cover property ($rose(amp_enable_out));
endmodule
bind plmc_modem plmc_chk #(.WDOG_CYC(WDOG_CYC), .HOLD_CYC(HOLD_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .tx_request_in(tx_request_in), .wdog_in(wdog_in), .tone_out(tone_out),
  .tx_phase_out(tx_phase_out), .lo_out(lo_out), .amp_enable_out(amp_enable_out),
  .carrier_detect_out(carrier_detect_out), .rx_data_valid_out(rx_data_valid_out),
  .host_restart_out(host_restart_out));
`default_nettype wire

/* File: verification/plmc_modem_tb.sv */
// Bench for the modem control block
`timescale 1ns/1ps
`default_nettype none
module plmc_modem_tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       line = 1'b0;
  logic       kick = 1'b1;
  logic       send = 1'b0;
  wire        req, txd, wd, tone, lo, amp, cd, rxd, rxv, rst_out;
  wire  [7:0] ph;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         rxv_n = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (rxv === 1'b1) rxv_n <= rxv_n + 1;
  plmc_modem #(.WDOG_CYC(28'h00007D0), .HOLD_CYC(16'h0010)) uut (
    .clk(clk), .sys_rst(sys_rst), .tx_request_in(req), .tx_data_in(txd), .rx_line_in(line),
    .wdog_in(wd), .tone_out(tone), .tx_phase_out(ph), .lo_out(lo), .amp_enable_out(amp),
    .carrier_detect_out(cd), .rx_data_out(rxd), .rx_data_valid_out(rxv), .host_restart_out(rst_out));
  plmc_host host (.clk(clk), .kick_en(kick), .send(send), .carrier_detect(cd), .tx_request(req),
    .tx_data(txd), .wdog(wd));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] lo_v, hi_v, got);
    total_checks++;
    if ((got >= lo_v && got <= hi_v) !== 1'b1) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo_v, hi_v, got);
    end
  endtask
  // Bounded wait for a level on tone, lo, bit or restart
  task automatic lvl(input int s, input logic v, inout int n);
    while ((s == 0 ? tone : s == 1 ? lo : s == 2 ? txd : rst_out) !== v && n < 9000) begin
      step(1);
      n++;
    end
  endtask
  task automatic period(input int s, lo_v, hi_v, input string nm);
    int n;
    n = 0;
    lvl(s, 1'b0, n);
    lvl(s, 1'b1, n);
    n = 0;
    lvl(s, 1'b0, n);
    lvl(s, 1'b1, n);
    chk(nm, lo_v, hi_v, n);
  endtask
  task automatic pulses(input int per, cnt);
    repeat (cnt) begin
      line = 1'b1;
      step(per / 2);
      line = 1'b0;
      step(per - per / 2);
    end
  endtask
  task automatic start_msg;
    send = 1'b1;
    step(1);
    send = 1'b0;
  endtask
  task automatic t_reset;
    step(12);
    sys_rst = 1'b0;
    step(1);
    chk("outputs", 0, 0, {tone, lo, amp, cd, rxd, rxv, rst_out, ph});
  endtask
  task automatic t_lo;
    period(1, 983, 985, "lo period");
  endtask
  task automatic t_carrier;
    pulses(948, 11);
    chk("carrier", 1, 1, cd);
    chk("rx words", 10, 10, rxv_n);
    chk("rx bit", 1, 1, rxd);
    start_msg();
    step(50);
    chk("deferred amp", 0, 0, amp);
    pulses(600, 2);
    chk("carrier lost", 0, 0, cd);
    pulses(940, 2);
    chk("carrier and bit", 0, 0, {cd, rxd});
  endtask
  task automatic t_tx;
    int n;
    start_msg();
    step(2);
    chk("amp on", 1, 1, amp);
    chk("lo in tx", 0, 0, lo);
    step(1000);
    period(0, 939, 940, "tone zero");
    n = 0;
    lvl(2, 1'b1, n);
    step(10);
    period(0, 947, 949, "tone one");
    step(4000);
    chk("amp off", 0, 0, amp);
    chk("phase idle", 0, 0, ph);
  endtask
  task automatic t_wdog;
    int n;
    kick = 1'b0;
    n = 0;
    lvl(3, 1'b1, n);
    n = 0;
    lvl(3, 1'b0, n);
    chk("restart length", 16, 16, n);
    kick = 1'b1;
    n = 0;
    repeat (4000) begin
      step(1);
      if (rst_out !== 1'b0)
        n++;
    end
    chk("restart while kicked", 0, 0, n);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #480000;
    error_cnt++;
    complete_run();
  end
  initial begin
    t_reset();
    t_lo();
    t_carrier();
    t_tx();
    t_wdog();
    complete_run();
  end
endmodule
`default_nettype wire
